// file: rtl/eew_host.sv
`timescale 1ns/1ps
module eew_host
	import eew_pkg::*;
#(
	parameter int PROGRAM_CYCLES = PROGRAM_CYC,
	parameter int PAGE_MAX = PAGE_BYTES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic req_last,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic wr_done,
	input wire logic cfg_ce_ctrl,
	input wire logic cfg_done_mode,
	input wire logic cfg_low_vcc,
	input wire logic cfg_protect,
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic [DATA_W-1:0] mem_data_in,
	output logic [DATA_W-1:0] mem_data_out,
	output logic mem_data_oe,
	output logic mem_ce_n,
	output logic mem_oe_n,
	output logic mem_we_n,
	output logic protect_reset_n,
	input wire logic ready_busy_n
);
	eew_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] space_q;
	logic [7:0] nbytes_q;
	logic [DATA_W-1:0] last_q;
	logic [ADDR_W-1:PAGE_LSB] page_q;
	logic [DATA_W-1:0] rdata_q;
	logic rsp_q, done_q, in_page_q, poll_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] dout_q;
	logic ce_q, oe_q, we_q, doe_q, prot_q;
	logic [DATA_W:0] pins_s;

	eew_sync #(.W(DATA_W + 1)) i_eew_sync (
		.clk(clk),
		.resetn(resetn),
		.d({ready_busy_n, mem_data_in}),
		.q(pins_s)
	);

	wire rb_low = ~pins_s[DATA_W];
	wire poll_bit = pins_s[DATA_W-1];
	wire [CNT_W-1:0] start_cyc = cfg_low_vcc ? CNT_W'(START_LO_CYC) : CNT_W'(START_HI_CYC);
	wire same_page = req_addr[ADDR_W-1:PAGE_LSB] == page_q;
	wire can_load = in_page_q && req_write && same_page && nbytes_q < 8'(PAGE_MAX);
	wire take = req_valid && req_ready;
	wire strobe_min = cnt_q >= CNT_W'(STROBE_MIN_CYC - 1);
	wire read_min = cnt_q >= CNT_W'(READ_CYC - 1);
	wire prog_over = cnt_q >= CNT_W'(PROGRAM_CYCLES - 1);
	wire gap_over = cnt_q >= start_cyc - CNT_W'(1);
	// The page stays open only while the next strobe can still fall in time.
	wire space_over = space_q >= CNT_W'(LOAD_SPACING_MAX_CYC - STROBE_MIN_CYC - 4);

	assign req_ready = prot_q && ((state_q == EEW_IDLE) || (state_q == EEW_STROBE_HI && can_load));

	always_comb begin
		state_d = state_q;
		case (state_q)
			EEW_IDLE: begin
				if (take) begin
					state_d = req_write ? EEW_STROBE_LO : EEW_READ;
				end
			end
			// Strobe leaves at the least width, well under the 30 us ceiling.
			EEW_STROBE_LO: begin
				if (strobe_min) begin
					state_d = EEW_STROBE_HI;
				end
			end
			EEW_STROBE_HI: begin
				if (take) begin
					state_d = EEW_STROBE_LO;
				end else if (done_q || space_over) begin
					state_d = EEW_WAIT_DONE;
				end
			end
			EEW_READ: begin
				if (read_min) begin
					state_d = EEW_GAP;
				end
			end
			EEW_WAIT_DONE: begin
				if (!cfg_done_mode && prog_over) begin
					state_d = EEW_GAP;
				end else if (cfg_done_mode && cnt_q >= CNT_W'(READ_CYC + 3)) begin
					state_d = EEW_POLL;
				end
			end
			EEW_POLL: begin
				if (read_min) begin
					state_d = EEW_WAIT_DONE;
					// Both senses must agree, so a glitch on one alone cannot end the wait.
					if (!rb_low && poll_bit == last_q[DATA_W-1]) begin
						state_d = EEW_GAP;
					end
				end
			end
			EEW_GAP: begin
				if (gap_over) begin
					state_d = EEW_IDLE;
				end
			end
			default: state_d = EEW_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= EEW_IDLE;
			cnt_q <= '0;
			space_q <= '0;
			nbytes_q <= '0;
			last_q <= '0;
			page_q <= '0;
			in_page_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= (state_d != state_q || state_q == EEW_POLL && read_min) ? '0 : cnt_q + 1'b1;
			if (state_q == EEW_STROBE_LO) begin
				space_q <= '0;
			end else begin
				space_q <= space_q + 1'b1;
			end
			if (take && req_write) begin
				// All bytes share the page of the first; the low bits pick the byte.
				if (!in_page_q) begin
					page_q <= req_addr[ADDR_W-1:PAGE_LSB];
					nbytes_q <= 8'd1;
				end else begin
					nbytes_q <= nbytes_q + 8'd1;
				end
				last_q <= req_wdata;
				done_q <= req_last;
				in_page_q <= 1'b1;
			end else if (state_q == EEW_WAIT_DONE) begin
				in_page_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_q <= '0;
			dout_q <= '0;
			doe_q <= 1'b0;
			ce_q <= 1'b1;
			oe_q <= 1'b1;
			we_q <= 1'b1;
			prot_q <= 1'b0;
			rdata_q <= '0;
			rsp_q <= 1'b0;
			wr_done <= 1'b0;
			poll_q <= 1'b0;
		end else begin
			prot_q <= ~cfg_protect;
			if (take) begin
				addr_q <= req_addr;
				dout_q <= req_wdata;
			end
			poll_q <= state_d == EEW_POLL;
			doe_q <= state_d == EEW_STROBE_LO;
			// Strobe-controlled keeps select low across the load; select-controlled pulses it.
			we_q <= !(state_d == EEW_STROBE_LO) && !(cfg_ce_ctrl && state_d == EEW_STROBE_HI);
			ce_q <= !(state_d == EEW_STROBE_LO || state_d == EEW_READ || state_d == EEW_POLL ||
				(!cfg_ce_ctrl && state_d == EEW_STROBE_HI));
			oe_q <= !(state_d == EEW_READ || state_d == EEW_POLL);
			rsp_q <= state_q == EEW_READ && state_d == EEW_GAP;
			if (state_q == EEW_READ && state_d == EEW_GAP) begin
				rdata_q <= pins_s[DATA_W-1:0];
			end
			wr_done <= state_q != EEW_READ && state_q != EEW_IDLE && state_d == EEW_GAP;
		end
	end

	assign mem_addr = addr_q;
	assign mem_data_out = dout_q;
	assign mem_data_oe = doe_q;
	assign mem_ce_n = ce_q;
	assign mem_oe_n = oe_q;
	assign mem_we_n = we_q;
	assign protect_reset_n = prot_q;
	assign rsp_valid = rsp_q;
	assign rsp_rdata = rdata_q;
endmodule : eew_host

// file: rtl/eew_pkg.sv
package eew_pkg;

	localparam int CLK_MHZ = 40;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int PAGE_LSB = 7;
	localparam int PAGE_BYTES = 128;

	// Times in their printed units.
	localparam int STROBE_MIN_NS = 250;
	localparam int STROBE_MAX_US = 30;
	localparam int LOAD_SPACING_MAX_US = 30;
	localparam int PROGRAM_TIME_MS = 10;
	localparam int START_DELAY_HI_NS = 150;
	localparam int START_DELAY_LO_NS = 250;
	localparam int READ_ACCESS_NS = 250;

	// Cycle counts: least times round up, longest times round down.
	localparam int STROBE_MIN_CYC = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_MAX_CYC = STROBE_MAX_US * CLK_MHZ;
	localparam int LOAD_SPACING_MAX_CYC = LOAD_SPACING_MAX_US * CLK_MHZ;
	localparam int PROGRAM_CYC = PROGRAM_TIME_MS * 1000 * CLK_MHZ;
	localparam int START_HI_CYC = (START_DELAY_HI_NS * CLK_MHZ + 999) / 1000;
	localparam int START_LO_CYC = (START_DELAY_LO_NS * CLK_MHZ + 999) / 1000;
	localparam int READ_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000 + 1;
	localparam int CNT_W = 20;

	typedef enum logic [2:0] {
		EEW_IDLE,
		EEW_STROBE_LO,
		EEW_STROBE_HI,
		EEW_READ,
		EEW_WAIT_DONE,
		EEW_POLL,
		EEW_GAP
	} eew_state_t;

endpackage : eew_pkg

// file: rtl/eew_sync.sv
`timescale 1ns/1ps
module eew_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// The first stage feeds only the second, to keep metastability contained.
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : eew_sync

// file: verif/eew_host_monitor.sv
`timescale 1ns/1ps
module eew_host_monitor
	import eew_pkg::*;
#(
	parameter int PROGRAM_CYCLES = PROGRAM_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic mem_we_n,
	input wire logic mem_ce_n,
	input wire logic wr_done,
	input wire logic cfg_ce_ctrl,
	input wire logic cfg_done_mode,
	input wire logic cfg_low_vcc,
	input wire logic ready_busy_n
);
	// A write is active only while both selects are low, so one counter serves both modes.
	wire sn = mem_we_n | mem_ce_n;
	logic [CNT_W-1:0] lo_q, hi_q, gap_q, rdy_q;
	logic open_q;
	// Set by a finished write, cleared by the next access that lowers the select.
	logic after_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{lo_q, hi_q, gap_q, rdy_q, open_q} <= '0;
			after_q <= 1'b0;
		end else begin
			after_q <= wr_done || (after_q && mem_ce_n);
			lo_q <= sn ? '0 : lo_q + 20'h0_0001;
			hi_q <= sn ? hi_q + 20'h0_0001 : '0;
			gap_q <= (!sn && lo_q == '0) ? '0 : gap_q + 20'h0_0001;
			rdy_q <= ready_busy_n ? rdy_q + 20'h0_0001 : '0;
			open_q <= !wr_done && (open_q || !sn);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_we_pulse;
		$rose(sn) && !cfg_ce_ctrl |-> lo_q >= STROBE_MIN_CYC && lo_q <= STROBE_MAX_CYC;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("strobe width");
	property p_ce_pulse;
		sn && lo_q != '0 && cfg_ce_ctrl |-> lo_q inside {[STROBE_MIN_CYC:STROBE_MAX_CYC]};
	endproperty
	a_ce_pulse: assert property (p_ce_pulse) else $error("select width");
	property p_spacing;
		!sn && lo_q == '0 && open_q |-> gap_q < LOAD_SPACING_MAX_CYC;
	endproperty
	a_spacing: assert property (p_spacing) else $error("byte spacing");
	property p_fixed_wait;
		wr_done && !cfg_done_mode |-> hi_q >= PROGRAM_CYCLES;
	endproperty
	a_fixed_wait: assert property (p_fixed_wait) else $error("early done");
	property p_start_gap;
		$fell(mem_ce_n) && after_q && cfg_done_mode |->
			rdy_q >= (cfg_low_vcc ? START_LO_CYC : START_HI_CYC);
	endproperty
	a_start_gap: assert property (p_start_gap) else $error("start gap");
endmodule : eew_host_monitor

// file: verif/eew_dev_model.sv
`timescale 1ns/1ps
module eew_dev_model #(
	parameter int BL_CYC = 40,
	parameter int PROG_CYC = 120
) (
	input wire logic clk,
	input wire logic [16:0] mem_addr,
	inout wire logic [7:0] dq,
	input wire logic mem_ce_n,
	input wire logic mem_oe_n,
	input wire logic mem_we_n,
	input wire logic protect_reset_n,
	output wire logic rb_n
);
	// Times are scaled so that programming ends inside the host's shortened wait.
	logic [7:0] m [0:131071];
	logic [7:0] pg [0:127];
	logic [127:0] pg_v = '0;
	logic [9:0] page = '0;
	logic [7:0] last = '0, d_q = '0;
	logic open = 0, busy = 0;
	int cnt = 0;
	wire s = mem_we_n | mem_ce_n;
	wire rd = !mem_ce_n && !mem_oe_n && mem_we_n;
	assign rb_n = open ? 1'h0 : 1'hz;
	assign dq = rd ? (open ? {~last[7], 7'h00} : m[mem_addr]) : 8'hzz;
	always @(negedge clk) if (!s) d_q = dq;
	always @(negedge s) if (protect_reset_n && !open) begin
		open = 1;
		page = mem_addr[16:7];
	end
	always @(posedge s) if (protect_reset_n && open && !busy) begin
		pg[mem_addr[6:0]] = d_q;
		pg_v[mem_addr[6:0]] = 1'b1;
		last = d_q;
		cnt = 0;
	end
	always @(posedge clk) if (open) begin
		cnt++;
		if (!busy && s && cnt >= BL_CYC) begin
			busy = 1;
			cnt = 0;
		end else if (busy && cnt >= PROG_CYC) begin
			for (int i = 0; i < 128; i++) begin
				if (pg_v[i]) m[{page, 7'(i)}] = pg[i];
			end
			pg_v = '0;
			{open, busy} = 2'h0;
		end
	end
endmodule : eew_dev_model

// file: verif/eew_host_tb.sv
`timescale 1ns/1ps
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("Error %0t %h %h", $time, a, b); end end
module eew_host_tb;
	import eew_pkg::*;
	logic clk = 0, resetn = 0, req_valid = 0, req_write = 0, req_last = 0;
	logic cfg_ce_ctrl = 0, cfg_done_mode = 0, cfg_low_vcc = 0, cfg_protect = 0;
	logic [ADDR_W-1:0] req_addr = '0, mem_addr;
	logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, mem_data_out;
	logic req_ready, rsp_valid, wr_done, mem_data_oe, mem_ce_n, mem_oe_n, mem_we_n;
	logic protect_reset_n;
	tri1 rb_n;
	wire [DATA_W-1:0] dq;
	int n_errors = 0, total_checks = 0, cyc = 0;
	assign dq = mem_data_oe ? mem_data_out : 8'hzz;
	always #12.5 clk = ~clk;
	eew_host #(.PROGRAM_CYCLES(200)) i_eew_host (
		.clk(clk),
		.resetn(resetn),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.req_write(req_write),
		.req_last(req_last),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.wr_done(wr_done),
		.cfg_ce_ctrl(cfg_ce_ctrl),
		.cfg_done_mode(cfg_done_mode),
		.cfg_low_vcc(cfg_low_vcc),
		.cfg_protect(cfg_protect),
		.mem_addr(mem_addr),
		.mem_data_in(dq),
		.mem_data_out(mem_data_out),
		.mem_data_oe(mem_data_oe),
		.mem_ce_n(mem_ce_n),
		.mem_oe_n(mem_oe_n),
		.mem_we_n(mem_we_n),
		.protect_reset_n(protect_reset_n),
		.ready_busy_n(rb_n)
	);
	eew_dev_model i_eew_dev_model (
		.clk(clk),
		.mem_addr(mem_addr),
		.dq(dq),
		.mem_ce_n(mem_ce_n),
		.mem_oe_n(mem_oe_n),
		.mem_we_n(mem_we_n),
		.protect_reset_n(protect_reset_n),
		.rb_n(rb_n)
	);
	task automatic rq(input logic w, l, input logic [16:0] ad, input logic [7:0] d);
		@(posedge clk);
		#1 {req_valid, req_write, req_last, req_addr, req_wdata} = {1'h1, w, l, ad, d};
		do @(posedge clk); while (req_ready !== 1'h1);
		#1 req_valid = 0;
	endtask : rq
	task automatic rd(input logic [16:0] ad, input logic [7:0] e);
		rq(0, 0, ad, '0);
		do @(posedge clk); while (rsp_valid !== 1'h1);
		`CK(rsp_rdata, e)
	endtask : rd
	task automatic wd;
		do @(posedge clk); while (wr_done !== 1'h1);
	endtask : wd
	task automatic t_page;
		rq(1, 0, 17'h0_0285, 8'h5a);
		rq(1, 0, 17'h0_0286, 8'h11);
		rq(1, 1, 17'h0_0285, 8'hc3);
		wd();
		`CK(rb_n, 1'h1)
		rd(17'h0_0285, 8'hc3);
		rd(17'h0_0286, 8'h11);
	endtask : t_page
	task automatic t_poll;
		#1 {cfg_ce_ctrl, cfg_done_mode, cfg_low_vcc} = 3'h7;
		rq(1, 1, 17'h1_ff80, 8'h80);
		wd();
		rd(17'h1_ff80, 8'h80);
	endtask : t_poll
	task automatic t_auto;
		#1 {cfg_ce_ctrl, cfg_done_mode, cfg_low_vcc} = 3'h2;
		rq(1, 0, 17'h0_0001, 8'h3c);
		wd();
		rd(17'h0_0001, 8'h3c);
	endtask : t_auto
	task automatic close_out;
		if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	initial begin
		repeat (3) @(posedge clk);
		#1 resetn = 1;
		t_page();
		t_poll();
		t_auto();
		close_out();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end
endmodule : eew_host_tb
bind eew_host eew_host_monitor #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) i_eew_host_monitor (
	.clk(clk),
	.resetn(resetn),
	.mem_we_n(mem_we_n),
	.mem_ce_n(mem_ce_n),
	.wr_done(wr_done),
	.cfg_ce_ctrl(cfg_ce_ctrl),
	.cfg_done_mode(cfg_done_mode),
	.cfg_low_vcc(cfg_low_vcc),
	.ready_busy_n(ready_busy_n)
);
